// ### buck_power_stage_gate_control.sv
module buck_power_stage_gate_control
(
	input  wire logic                   clock,
	input  wire logic                   reset,
	input  wire gate_ctrl_pkg::tri_pin_t pwm_pin,
	input  wire gate_ctrl_pkg::tri_pin_t zero_cross_mode_sel,
	input  wire logic                   stage_enable_n,
	input  wire gate_ctrl_pkg::sense_t   sense,
	output logic                        high_gate,
	output logic                        low_gate,
	output logic                        temp_fault_out,
	output logic                        overtemp_flag,
	output logic                        overcurrent_trip
);
	import gate_ctrl_pkg::*;

	typedef struct packed
	{
		gate_state_t       state;
		level_t            pwm;
		level_t            mode;
		logic [TIMER_W-1:0] mid_qual;
		logic [TIMER_W-1:0] mode_qual;
		logic [TIMER_W-1:0] dead;
		logic [TIMER_W-1:0] blank;
		logic [TIMER_W-1:0] holdoff;
		logic [TIMER_W-1:0] refresh;
		logic              zc_armed;
		logic              zc_released;
		logic              refreshing;
		logic              oc_block;
		logic              oc_seen;
		logic [3:0]        oc_count;
		logic              oc_fault;
		logic              ot_flag;
		logic              high_gate;
		logic              low_gate;
		logic              fault;
	} state_t;

	state_t state_reg;
	state_t state_next;

	level_t pwm_raw;
	level_t mode_raw;
	logic   enabled;
	logic   want_high;
	logic   want_low;
	logic   blank_done;

	// Raw decode of each three-level pin; neither comparator means middle
	always_comb
	begin
		if (pwm_pin.above_high)
			pwm_raw = LVL_HIGH;
		else if (pwm_pin.below_low)
			pwm_raw = LVL_LOW;
		else
			pwm_raw = LVL_MID;
		// An open select floats to the divider midpoint
		if (zero_cross_mode_sel.above_high)
			mode_raw = LVL_HIGH;
		else if (zero_cross_mode_sel.below_low)
			mode_raw = LVL_LOW;
		else
			mode_raw = LVL_MID;
	end

	assign enabled    = !stage_enable_n && sense.power_ready;
	assign blank_done = (state_reg.blank == '0);

	// Desired gate from decoded PWM and mode
	always_comb
	begin
		want_high = 1'b0;
		want_low  = 1'b0;
		case (state_reg.pwm)
			LVL_HIGH:
			begin
				want_high = !state_reg.oc_block;
			end
			LVL_LOW:
			begin
				if (state_reg.mode == LVL_MID)
					want_low = state_reg.low_gate ? !(state_reg.zc_armed
						&& blank_done && sense.zero_cross_detect) : !state_reg.zc_released;
				else
					want_low = 1'b1;
			end
			LVL_MID:
			begin
				if (state_reg.mode == LVL_HIGH)
					want_low = state_reg.low_gate ? !(blank_done && sense.zero_cross_detect)
						: (state_reg.holdoff != '0);
				else if (state_reg.mode == LVL_MID && state_reg.zc_armed)
					want_low = !(blank_done && sense.zero_cross_detect);
				else
					want_low = 1'b0;
			end
			default:
			begin
				want_high = 1'b0;
				want_low  = 1'b0;
			end
		endcase
	end

	// Next state of the whole stage
	always_comb
	begin
		state_next = state_reg;

		// Middle level counts only after it has stood for the qualify time
		if (pwm_raw == LVL_MID)
		begin
			if (state_reg.mid_qual < TIMER_W'(MID_QUAL_CYC))
				state_next.mid_qual = state_reg.mid_qual + 1'b1;
			else
				state_next.pwm = LVL_MID;
		end
		else
		begin
			state_next.mid_qual = '0;
			state_next.pwm      = pwm_raw;
			state_next.zc_released = state_reg.zc_released && (pwm_raw == state_reg.pwm);
		end
		if (mode_raw == LVL_MID)
		begin
			if (state_reg.mode_qual < TIMER_W'(MID_QUAL_CYC))
				state_next.mode_qual = state_reg.mode_qual + 1'b1;
			else
				state_next.mode = LVL_MID;
		end
		else
		begin
			state_next.mode_qual = '0;
			state_next.mode      = mode_raw;
		end

		// Hold-off counter for the three-state window
		if (state_reg.pwm == LVL_MID)
		begin
			if (state_reg.holdoff != '0)
				state_next.holdoff = state_reg.holdoff - 1'b1;
		end
		else
			state_next.holdoff = TIMER_W'(HOLDOFF_CYC);

		// Blanking restarts when the low gate turns on after dead time, not on refresh pulses
		if (state_reg.blank != '0)
			state_next.blank = state_reg.blank - 1'b1;
		if (state_reg.dead != '0)
			state_next.dead = state_reg.dead - 1'b1;

		// Overcurrent: truncate high gate only, with hysteresis
		if (sense.over_current)
			state_next.oc_block = 1'b1;
		else if (sense.over_current_clear)
			state_next.oc_block = 1'b0;
		if (sense.over_current && state_reg.high_gate)
			state_next.oc_seen = 1'b1;

		// Overtemperature with hysteresis; gates keep following PWM
		if (sense.temp_above_140)
			state_next.ot_flag = 1'b1;
		else if (sense.temp_below_125)
			state_next.ot_flag = 1'b0;

		// Bootstrap refresh request and end
		if (enabled && sense.boot_below_low)
			state_next.refreshing = 1'b1;
		else if (sense.boot_above_high || !enabled)
			state_next.refreshing = 1'b0;
		if (state_reg.refresh != '0)
			state_next.refresh = state_reg.refresh - 1'b1;

		case (state_reg.state)
			ST_OFF:
			begin
				state_next.high_gate = 1'b0;
				state_next.low_gate  = 1'b0;
				if (!enabled)
					state_next.state = ST_OFF;
				else if (state_reg.refreshing)
				begin
					state_next.state   = ST_REFRESH;
					state_next.refresh = TIMER_W'(REFRESH_ON_CYC);
				end
				else if (want_high && state_reg.holdoff != '0)
				begin
					state_next.state = ST_DEAD_TO_HIGH;
					state_next.dead  = TIMER_W'(DEAD_CYC);
				end
				else if (want_low)
				begin
					state_next.state = ST_DEAD_TO_LOW;
					state_next.dead  = TIMER_W'(DEAD_CYC);
				end
				else
					state_next.state = ST_OFF;
			end
			ST_HIGH_ON:
			begin
				if (!enabled || !want_high || state_reg.refreshing)
				begin
					// Cycle ends: update consecutive overcurrent count
					state_next.high_gate = 1'b0;
					state_next.state     = ST_DEAD_TO_LOW;
					state_next.dead      = TIMER_W'(DEAD_CYC);
					if (state_reg.oc_seen || sense.over_current)
					begin
						if (state_reg.oc_count < 4'(OC_FAULT_COUNT))
							state_next.oc_count = state_reg.oc_count + 1'b1;
					end
					else
						state_next.oc_count = '0;
					state_next.oc_seen = 1'b0;
				end
			end
			ST_DEAD_TO_LOW:
			begin
				if (!enabled)
					state_next.state = ST_OFF;
				else if (state_reg.dead == '0)
				begin
					if (want_low && !state_reg.refreshing)
					begin
						state_next.low_gate = 1'b1;
						state_next.state    = ST_LOW_ON;
						state_next.blank    = TIMER_W'(BLANK_CYC);
						state_next.zc_armed = 1'b1;
					end
					else
						state_next.state = ST_OFF;
				end
			end
			ST_LOW_ON:
			begin
				if (!enabled)
				begin
					state_next.low_gate = 1'b0;
					state_next.state    = ST_OFF;
				end
				else if (state_reg.refreshing)
				begin
					state_next.low_gate = 1'b0;
					state_next.state    = ST_OFF;
				end
				else if (want_high)
				begin
					state_next.low_gate = 1'b0;
					state_next.state    = ST_DEAD_TO_HIGH;
					state_next.dead     = TIMER_W'(DEAD_CYC);
					state_next.zc_armed = 1'b0;
				end
				else if (!want_low)
				begin
					state_next.low_gate = 1'b0;
					state_next.state    = ST_OFF;
					state_next.zc_released = 1'b1;
					state_next.zc_armed = 1'b0;
				end
			end
			ST_DEAD_TO_HIGH:
			begin
				if (!enabled || !want_high || state_reg.refreshing)
					state_next.state = ST_OFF;
				else if (state_reg.dead == '0)
				begin
					state_next.high_gate = 1'b1;
					state_next.state     = ST_HIGH_ON;
				end
			end
			ST_REFRESH:
			begin
				// PWM ignored; short low gate pulse each period
				state_next.high_gate = 1'b0;
				if (!state_reg.refreshing || !enabled)
				begin
					state_next.low_gate = 1'b0;
					state_next.state    = ST_OFF;
				end
				else if (state_reg.refresh == '0)
				begin
					state_next.low_gate = !state_reg.low_gate;
					state_next.refresh  = state_reg.low_gate ?
						TIMER_W'(REFRESH_PER_CYC - REFRESH_ON_CYC) :
						TIMER_W'(REFRESH_ON_CYC);
				end
			end
			default:
			begin
				state_next.state     = ST_OFF;
				state_next.high_gate = 1'b0;
				state_next.low_gate  = 1'b0;
			end
		endcase

		// Long middle level forces the high gate off
		if (state_reg.pwm == LVL_MID && state_reg.holdoff == '0)
			state_next.high_gate = 1'b0;

		state_next.oc_fault = (state_next.oc_count >= 4'(OC_FAULT_COUNT));
		// Held low before power ready, else any fault source
		state_next.fault = sense.power_ready && (state_next.oc_fault
			|| state_reg.refreshing || state_next.ot_flag);
	end

	// State register; every output is one of its bits
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			state_reg          <= '0;
			state_reg.state    <= ST_OFF;
			state_reg.pwm      <= LVL_MID;
			state_reg.mode     <= LVL_MID;
		end
		else
			state_reg <= state_next;
	end

	assign high_gate        = state_reg.high_gate;
	assign low_gate         = state_reg.low_gate;
	assign temp_fault_out   = state_reg.fault;
	assign overtemp_flag    = state_reg.ot_flag;
	assign overcurrent_trip = state_reg.oc_block;

	// Gates never overlap
	AST_NO_OVERLAP: assert property (@(posedge clock) disable iff (reset)
		!(high_gate && low_gate))
		else $error("both gates on");

	AST_DISABLE_OFF: assert property (@(posedge clock) disable iff (reset)
		stage_enable_n |=> !high_gate && !low_gate)
		else $error("gate on while disabled");

	AST_FAULT_PWR: assert property (@(posedge clock) disable iff (reset)
		!sense.power_ready |=> !temp_fault_out)
		else $error("fault high before power ready");

	AST_OT_FLAG: assert property (@(posedge clock) disable iff (reset)
		sense.temp_above_140 |=> overtemp_flag)
		else $error("overtemp flag missed");

	AST_OC_BLOCK: assert property (@(posedge clock) disable iff (reset)
		overcurrent_trip |=> !$rose(high_gate))
		else $error("high gate rose during overcurrent");

	sequence dead_gap;
		!low_gate [*2];
	endsequence

	AST_HIGH_AFTER_DEAD: assert property (@(posedge clock) disable iff (reset)
		$rose(high_gate) |-> $past(!low_gate, 2))
		else $error("no dead time before high gate");

	AST_BLANK_HOLD: assert property (@(posedge clock) disable iff (reset)
		$rose(low_gate) && state_reg.state == ST_LOW_ON && enabled && !sense.boot_below_low
		&& state_reg.pwm == LVL_MID ##1 (enabled && pwm_raw != LVL_HIGH) [*3]
		|-> low_gate)
		else $error("low gate dropped inside blanking");

	AST_OC_FAULT: assert property (@(posedge clock) disable iff (reset)
		state_reg.oc_count >= 4'(OC_FAULT_COUNT) && $past(sense.power_ready) |-> temp_fault_out)
		else $error("overcurrent fault not raised");

endmodule

// ### gate_ctrl_pkg.sv
// Function
// - Open mode select reads as middle level
// - Mode high: middle PWM, high off, low on
// - Low gate held through blanking, then zero-cross release
// - Early zero current: hold low gate until blanking ends
// - Late zero current: hold low gate until detected
// - Middle-low-middle: blanking starts at low, held
// - Mode middle: low gate released at zero cross
// - Mode low: middle PWM turns both gates off
// - High gate follows PWM in phase
// - High gate low when disabled or long middle
// - Low gate inverse of PWM, low when disabled
// - Dead time on both gate handovers
// - Low bootstrap voltage: ignore PWM, refresh
// - Refresh pulse 100-200 ns every 7-14 us
// - Fault output low until power ready
// - Fault on overcurrent, bootstrap low, overtemperature
// - Overtemperature flag set 140C, cleared 125C
// - Overcurrent truncates high gate with hysteresis
// - Ten consecutive overcurrent cycles raise fault
// - Overcurrent never disables the drivers
// - Enable low forces both gates low; here stage_enable_n is active low, so stage_enable_n high forces them low
package gate_ctrl_pkg;

	localparam int unsigned CLK_HZ         = 40_000_000;
	localparam int unsigned DEAD_NS        = 20;
	localparam int unsigned DEAD_CYC       = (DEAD_NS * 40 + 999) / 1000 < 1 ? 1 :
		(DEAD_NS * 40 + 999) / 1000;
	localparam int unsigned BLANK_NS       = 300;
	localparam int unsigned BLANK_CYC      = (BLANK_NS * 40 + 999) / 1000;
	localparam int unsigned HOLDOFF_NS     = 100;
	localparam int unsigned HOLDOFF_CYC    = (HOLDOFF_NS * 40 + 999) / 1000;
	localparam int unsigned MID_QUAL_NS    = 50;
	localparam int unsigned MID_QUAL_CYC   = (MID_QUAL_NS * 40 + 999) / 1000;
	localparam int unsigned REFRESH_ON_NS  = 150;
	localparam int unsigned REFRESH_ON_CYC = (REFRESH_ON_NS * 40) / 1000;
	localparam int unsigned REFRESH_PER_NS = 10_000;
	localparam int unsigned REFRESH_PER_CYC = (REFRESH_PER_NS * 40) / 1000;
	localparam int unsigned OC_FAULT_COUNT = 10;
	localparam int unsigned TIMER_W        = 10;

	typedef enum logic [1:0]
	{
		LVL_LOW,
		LVL_HIGH,
		LVL_MID
	} level_t;

	// Raw comparator outputs of a three-level pin
	typedef struct packed
	{
		logic above_high;
		logic below_low;
	} tri_pin_t;

	typedef enum logic [2:0]
	{
		ST_OFF,
		ST_HIGH_ON,
		ST_DEAD_TO_LOW,
		ST_LOW_ON,
		ST_DEAD_TO_HIGH,
		ST_REFRESH
	} gate_state_t;

	// Analog sense comparators, already synchronous
	typedef struct packed
	{
		logic power_ready;
		logic boot_below_low;
		logic boot_above_high;
		logic over_current;
		logic over_current_clear;
		logic temp_above_140;
		logic temp_below_125;
		logic zero_cross_detect;
	} sense_t;

endpackage

// ### pwm_controller_model.sv
module pwm_controller_model
	import gate_ctrl_pkg::*;
(
	input  wire logic                   clock,
	input  wire gate_ctrl_pkg::level_t   cmd,
	input  wire logic                   dcm_stop,
	input  wire logic                   zero_seen,
	output gate_ctrl_pkg::tri_pin_t      pwm
);
	timeunit 1ns;
	timeprecision 100ps;

	// Open output until the first edge reads as middle
	initial
		pwm = 2'h0;

	// Controller output moves just after the edge, never on it
	always @(posedge clock)
	begin
		#2;
		if (dcm_stop && zero_seen)
			pwm <= 2'h0;
		else
			pwm <= {cmd == LVL_HIGH, cmd == LVL_LOW};
	end
endmodule

// ### tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import gate_ctrl_pkg::*;

	logic     clock;
	logic     reset;
	logic     stage_enable_n;
	logic     high_gate;
	logic     low_gate;
	logic     temp_fault_out;
	logic     overtemp_flag;
	logic     overcurrent_trip;
	logic     dcm_stop;
	tri_pin_t pwm_pin;
	tri_pin_t mode_sel;
	sense_t   sense;
	level_t   cmd;
	int       mismatches;
	int       total_checks;

	buck_power_stage_gate_control i_dut
	(
		.clock               (clock),
		.reset               (reset),
		.pwm_pin             (pwm_pin),
		.zero_cross_mode_sel (mode_sel),
		.stage_enable_n      (stage_enable_n),
		.sense               (sense),
		.high_gate           (high_gate),
		.low_gate            (low_gate),
		.temp_fault_out      (temp_fault_out),
		.overtemp_flag       (overtemp_flag),
		.overcurrent_trip    (overcurrent_trip)
	);

	pwm_controller_model i_ctrl
	(
		.clock     (clock),
		.cmd       (cmd),
		.dcm_stop  (dcm_stop),
		.zero_seen (sense.zero_cross_detect),
		.pwm       (pwm_pin)
	);

	// 40 MHz clock
	initial
	begin
		clock = 1'h0;
		forever #12.5 clock = ~clock;
	end

	function automatic logic pick(input int sel);
		case (sel)
			0: return high_gate;
			1: return low_gate;
			2: return temp_fault_out;
			3: return overtemp_flag;
			default: return overcurrent_trip;
		endcase
	endfunction

	// Inputs always move a fixed 2 ns after the edge
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask

	task automatic chk(input logic got, input logic exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	// Bounded wait; a miss ends the run so later steps do not cascade
	task automatic wait_for(input int sel, input logic val, input int lim);
		int i;
		for (i = 0; i < lim && pick(sel) !== val; i++)
			step(1);
		chk(pick(sel), val);
		if (pick(sel) !== val)
			conclude();
	endtask

	task automatic hold(input int sel, input logic val, input int n);
		repeat (n)
		begin
			chk(pick(sel), val);
			step(1);
		end
	endtask

	task automatic go(input level_t l, input int sel, input logic v);
		cmd = l;
		wait_for(sel, v, 10);
	endtask

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic t_follow();
		go(LVL_HIGH, 0, 1);
		chk(low_gate, 1'h0);
		go(LVL_LOW, 0, 0);
		chk(low_gate, 1'h0);
		wait_for(1, 1, 8);
	endtask

	// Zero current seen inside blanking must not release the low gate
	task automatic t_zc_early();
		go(LVL_HIGH, 0, 1);
		sense.zero_cross_detect = 1'h1;
		go(LVL_MID, 0, 0);
		wait_for(1, 1, 8);
		hold(1, 1, BLANK_CYC - 2);
		wait_for(1, 0, 6);
		sense.zero_cross_detect = 1'h0;
	endtask

	task automatic t_zc_late();
		go(LVL_HIGH, 0, 1);
		go(LVL_MID, 1, 1);
		hold(1, 1, 20);
		sense.zero_cross_detect = 1'h1;
		wait_for(1, 0, 6);
		go(LVL_LOW, 1, 1);
		step(2);
		cmd = LVL_MID;
		hold(1, 1, 6);
		wait_for(1, 0, 10);
		sense.zero_cross_detect = 1'h0;
	endtask

	task automatic t_modes();
		mode_sel = 2'h1;
		go(LVL_HIGH, 0, 1);
		go(LVL_LOW, 1, 1);
		sense.zero_cross_detect = 1'h1;
		hold(1, 1, 20);
		dcm_stop = 1'h1;
		wait_for(1, 0, 6);
		chk(high_gate, 1'h0);
		dcm_stop = 1'h0;
		sense.zero_cross_detect = 1'h0;
		mode_sel = 2'h0;
		go(LVL_HIGH, 0, 1);
		go(LVL_LOW, 1, 1);
		sense.zero_cross_detect = 1'h1;
		wait_for(1, 0, 16);
		go(LVL_MID, 0, 0);
		hold(1, 0, 4);
		sense.zero_cross_detect = 1'h0;
		mode_sel = 2'h2;
		go(LVL_LOW, 1, 1);
	endtask

	// Clear is given only with PWM low so no clean period sneaks in
	task automatic t_oc();
		int k;
		for (k = 0; k < 10; k++)
		begin
			go(LVL_HIGH, 0, 1);
			sense.over_current = 1'h1;
			wait_for(4, 1, 4);
			wait_for(0, 0, 4);
			sense.over_current = 1'h0;
			step(3);
			chk(high_gate, 1'h0);
			if (k == 8)
				chk(temp_fault_out, 1'h0);
			cmd = LVL_LOW;
			step(3);
			sense.over_current_clear = 1'h1;
			wait_for(1, 1, 10);
			sense.over_current_clear = 1'h0;
		end
		wait_for(2, 1, 6);
		go(LVL_HIGH, 0, 1);
		go(LVL_LOW, 1, 1);
		wait_for(2, 0, 6);
	endtask

	task automatic t_temp();
		sense.temp_above_140 = 1'h1;
		wait_for(3, 1, 4);
		wait_for(2, 1, 4);
		go(LVL_HIGH, 0, 1);
		sense.power_ready = 1'h0;
		wait_for(2, 0, 6);
		sense.power_ready = 1'h1;
		sense.temp_above_140 = 1'h0;
		step(4);
		chk(overtemp_flag, 1'h1);
		sense.temp_below_125 = 1'h1;
		wait_for(3, 0, 4);
		wait_for(2, 0, 4);
		sense.temp_below_125 = 1'h0;
	endtask

	task automatic t_refresh();
		int n;
		int g;
		go(LVL_HIGH, 0, 1);
		sense.boot_below_low = 1'h1;
		wait_for(0, 0, 6);
		wait_for(2, 1, 6);
		wait_for(1, 1, 600);
		for (n = 0; n < 20 && low_gate === 1'h1; n++)
			step(1);
		for (g = 0; g < 700 && low_gate !== 1'h1; g++)
			step(1);
		chk(n >= 4 && n <= 8, 1'h1);
		chk(n + g >= 280 && n + g <= 560, 1'h1);
		chk(high_gate, 1'h0);
		sense.boot_below_low = 1'h0;
		sense.boot_above_high = 1'h1;
		cmd = LVL_LOW;
		step(12);
		hold(1, 1, 4);
		wait_for(2, 0, 6);
		sense.boot_above_high = 1'h0;
	endtask

	task automatic t_disable();
		go(LVL_HIGH, 0, 1);
		stage_enable_n = 1'h1;
		wait_for(0, 0, 6);
		cmd = LVL_LOW;
		hold(1, 0, 8);
		stage_enable_n = 1'h0;
		wait_for(1, 1, 10);
	endtask

	// Reset for 20 cycles, then each scenario in turn
	initial
	begin
		reset = 1'h1;
		stage_enable_n = 1'h0;
		cmd = LVL_MID;
		dcm_stop = 1'h0;
		mode_sel = 2'h2;
		sense = '0;
		sense.power_ready = 1'h1;
		mismatches = 0;
		total_checks = 0;
		step(20);
		reset = 1'h0;
		step(2);
		go(LVL_LOW, 1, 1);
		t_follow();
		t_zc_early();
		t_zc_late();
		t_modes();
		t_oc();
		t_temp();
		t_refresh();
		t_disable();
		conclude();
	end
endmodule
